/* verilog/timer_unit.sv */
`timescale 1ns/100ps
`default_nettype none
`include "timer_defs.svh"

// Summary of operation
// RULE1 - Each channel picks capture, compare or edge PWM independently of the others.
// RULE2 - One global bit forces center-aligned PWM on all channels, other modes unavailable.
// RULE3 - During background debug all counting halts until normal operation resumes.
// RULE4 - In stop mode clocks halt, so the timer does nothing.
// RULE5 - In wait mode the timer keeps running as in run mode.
// RULE6 - Capture edge copies the counter into the channel value and sets the flag.
// RULE7 - Capture edge is rising, falling, either, or none which disables the channel.
// RULE8 - Compare match of counter and channel value sets flag and applies pin action.
// RULE9 - Compare action is clear, set, toggle, or leave pin untouched.
// RULE10 - Edge PWM period is modulo value plus one counter ticks.
// RULE11 - Edge PWM duty comes from channel value; polarity chosen per channel.
// RULE12 - Edge PWM raises flags at period end and at the duty transition.
// RULE13 - Edge PWM leading edges of all channels align to the shared period start.
// RULE14 - Center PWM period is twice modulo; channel value sets half active time.
// RULE15 - Center PWM counter counts up to modulo, then down to zero, repeating.
// RULE16 - Center PWM goes active on down-count match, inactive on up-count match.
// RULE17 - Modulo of all zeros or all ones gives a free-running full-range counter.
// RULE18 - Counter reads never disturb counting.
// RULE19 - Any write to the counter resets it regardless of data.
// RULE20 - With no timer function enabled, pin control returns to the port logic.
// RULE21 - After reset no function is enabled; all pins are under port control.
// RULE22 - Channel count is a build parameter from one to eight, one pin each.
// RULE23 - External count clock is synchronised; source at most a quarter bus rate.
// RULE24 - Capture inputs are synchronised; pulses must last four bus clocks.
// RULE25 - High-true edge PWM sets pin at count zero, clears on match; low-true inverts.
// RULE26 - Channel flags stay set until cleared; request only when interrupt enabled.
module timer_unit #(
  parameter int CHANNELS = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic timer_enable,
  input wire logic ext_clk_select,
  input wire logic [2:0] prescale,
  input wire logic center_mode_select,
  input wire logic background_debug_mode,
  input wire logic [15:0] modulo_value,
  input wire logic count_write,
  input wire logic external_count_clock,
  input wire logic overflow_clear,
  input wire logic overflow_int_enable,
  input wire logic [2*CHANNELS-1:0] mode_select,
  input wire logic [2*CHANNELS-1:0] edge_level_select,
  input wire logic [CHANNELS-1:0] channel_value_wr,
  input wire logic [16*CHANNELS-1:0] channel_value_in,
  input wire logic [CHANNELS-1:0] flag_clear,
  input wire logic [CHANNELS-1:0] channel_int_enable,
  input wire logic [CHANNELS-1:0] channel_pin_in,
  output logic [15:0] timer_count,
  output logic overflow_flag,
  output logic overflow_request,
  output logic [16*CHANNELS-1:0] channel_value,
  output logic [CHANNELS-1:0] channel_flag,
  output logic [CHANNELS-1:0] channel_request,
  output logic [CHANNELS-1:0] channel_owns_pin,
  output logic [CHANNELS-1:0] channel_pin_out,
  output logic [CHANNELS-1:0] channel_pin_oe
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic down_reg;
  logic down_next;
  logic [6:0] pre_reg;
  logic ovf_reg;
  logic ovf_req_reg;
  logic [15:0] cv_reg [CHANNELS];
  logic [CHANNELS-1:0] flag_reg;
  logic [CHANNELS-1:0] req_reg;
  logic [CHANNELS-1:0] owns_reg;
  logic [CHANNELS-1:0] oe_reg;
  logic [CHANNELS-1:0] pin_reg;
  wire [15:0] cv_next [CHANNELS];
  wire [CHANNELS-1:0] pin_next;
  wire [CHANNELS-1:0] set_ev;
  wire [CHANNELS-1:0] cap_ev;
  wire [CHANNELS-1:0] match_ev;
  wire [CHANNELS-1:0] on_next;
  wire [CHANNELS-1:0] oe_next;
  wire [CHANNELS-1:0] flag_next;
  wire ext_rise;

  // External count clock through the bus-clock synchroniser
  input_sync u_ext_sync (  // see RULE23
    .clk(clk),
    .rst_b(rst_b),
    .async_in(external_count_clock),
    .rise(ext_rise),
    .fall()
  );

  // Count limit and prescaler decode
  wire free_run = (modulo_value == `COUNT_ZERO) || (modulo_value == `COUNT_FULL);  // see RULE17
  wire [15:0] top = free_run ? `COUNT_FULL : modulo_value;
  wire at_top = (count_reg == top);
  wire at_zero = (count_reg == `COUNT_ZERO);
  wire src_tick = ext_clk_select ? ext_rise : 1'b1;
  wire [7:0] pre_span = `PRE_ONE << prescale;
  wire [6:0] pre_mask = pre_span[6:0] - `PRE_STEP;
  // No wait input: wait mode counts exactly as run mode (see RULE5)
  wire run = timer_enable && !background_debug_mode;  // see RULE3
  wire src_step = run && src_tick;
  wire tick = src_step && ((pre_reg & pre_mask) == pre_mask) && !count_write;  // see RULE19
  wire period_end = tick && at_top;  // see RULE12
  wire period_start = period_end && !center_mode_select;  // see RULE13

  // Counter next value, up or up/down
  always_comb begin
    count_next = count_reg;
    down_next = down_reg;
    if (count_write) begin
      count_next = `COUNT_ZERO;  // see RULE19
      down_next = 1'b0;
    end else if (tick) begin
      if (!center_mode_select) begin
        count_next = at_top ? `COUNT_ZERO : count_reg + `COUNT_ONE;  // see RULE10
        down_next = 1'b0;
      end else if (down_reg) begin
        if (at_zero) begin
          down_next = 1'b0;  // see RULE15
          count_next = count_reg + `COUNT_ONE;
        end else begin
          count_next = count_reg - `COUNT_ONE;
        end
      end else if (at_top) begin
        down_next = 1'b1;  // see RULE14
        count_next = count_reg - `COUNT_ONE;
      end else begin
        count_next = count_reg + `COUNT_ONE;
      end
    end
  end

  // Counter, direction and prescaler; a stopped clock freezes all of it (see RULE4)
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_reg <= `COUNT_ZERO;
      down_reg <= 1'b0;
      pre_reg <= 7'h00;
    end else begin
      count_reg <= count_next;
      down_reg <= down_next;
      if (count_write) begin
        pre_reg <= 7'h00;
      end else if (src_step) begin
        pre_reg <= pre_reg + `PRE_STEP;
      end
    end
  end

  // Per-channel function, events and pin action
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch  // see RULE22
    wire [1:0] els = edge_level_select[2*i+:2];
    wire [1:0] ms = mode_select[2*i+:2];
    wire on = timer_enable && (els != `ELS_NONE);  // see RULE7
    wire rise;
    wire fall;
    timer_pkg::chan_fn_e fn;
    logic pin_n;

    input_sync u_pin_sync (  // see RULE24
      .clk(clk),
      .rst_b(rst_b),
      .async_in(channel_pin_in[i]),
      .rise(rise),
      .fall(fall)
    );

    // Mode decode: the global center bit overrides per-channel modes
    assign fn = !on ? timer_pkg::fn_off :
                center_mode_select ? timer_pkg::fn_center_pwm :  // see RULE2
                ms[1] ? timer_pkg::fn_edge_pwm :  // see RULE1
                ms[0] ? timer_pkg::fn_compare : timer_pkg::fn_capture;

    // Edge selection: low bit rising, high bit falling
    assign cap_ev[i] = (fn == timer_pkg::fn_capture) && ((els[0] && rise) || (els[1] && fall));
    assign match_ev[i] = tick && (count_next == cv_reg[i]);
    assign set_ev[i] = cap_ev[i] || (match_ev[i] && (fn != timer_pkg::fn_capture) &&
                       (fn != timer_pkg::fn_off));  // see RULE8
    assign cv_next[i] = cap_ev[i] ? count_reg :  // see RULE6
                        channel_value_wr[i] ? channel_value_in[16*i+:16] : cv_reg[i];
    assign on_next[i] = on;  // see RULE20
    assign oe_next[i] = on && (fn != timer_pkg::fn_capture);

    // Pin action for each output mode
    always_comb begin
      pin_n = pin_reg[i];
      case (fn)
        timer_pkg::fn_compare: begin
          if (match_ev[i]) begin
            pin_n = (els == `ELS_TOGGLE) ? !pin_reg[i] : els[0];  // see RULE9
          end
        end
        timer_pkg::fn_edge_pwm: begin
          if (match_ev[i]) begin
            pin_n = els[0];  // see RULE11
          end else if (period_start) begin
            pin_n = !els[0];  // see RULE25
          end
        end
        timer_pkg::fn_center_pwm: begin
          if (match_ev[i]) begin
            pin_n = down_next ? !els[0] : els[0];  // see RULE16
          end
        end
        default: begin
          pin_n = pin_reg[i];
        end
      endcase
    end
    assign pin_next[i] = pin_n;
    assign channel_value[16*i+:16] = cv_reg[i];
  end

  // Sticky flags: a new event beats a clear in the same cycle
  assign flag_next = set_ev | (flag_reg & ~flag_clear);  // see RULE26
  wire ovf_next = period_end || (ovf_reg && !overflow_clear);

  // Channel state registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_reg <= '0;
      req_reg <= '0;
      owns_reg <= '0;  // see RULE21
      oe_reg <= '0;
      pin_reg <= '0;
      ovf_reg <= 1'b0;
      ovf_req_reg <= 1'b0;
      for (int k = 0; k < CHANNELS; k++) begin
        cv_reg[k] <= `COUNT_ZERO;
      end
    end else begin
      flag_reg <= flag_next;
      req_reg <= flag_next & channel_int_enable;  // see RULE26
      owns_reg <= on_next;
      oe_reg <= oe_next;
      pin_reg <= pin_next;
      ovf_reg <= ovf_next;
      ovf_req_reg <= ovf_next && overflow_int_enable;
      for (int k = 0; k < CHANNELS; k++) begin
        cv_reg[k] <= cv_next[k];
      end
    end
  end

  // Outputs straight from registers; counter reads have no side effect
  assign timer_count = count_reg;  // see RULE18
  assign overflow_flag = ovf_reg;
  assign overflow_request = ovf_req_reg;
  assign channel_flag = flag_reg;
  assign channel_request = req_reg;
  assign channel_owns_pin = owns_reg;
  assign channel_pin_oe = oe_reg;
  assign channel_pin_out = pin_reg;

  // Checks on the counter, channel 0 and the last channel
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_debug_freeze: assert property (  // see RULE3
    (background_debug_mode && !count_write) |=> (timer_count == $past(timer_count)))
    else $error("Counter moved during debug halt");

  chk_count_reset: assert property (  // see RULE19
    count_write |=> (timer_count == `COUNT_ZERO))
    else $error("Counter write did not reset count");

  chk_free_wrap: assert property (  // see RULE17
    (tick && !center_mode_select && !count_write && free_run &&
     (count_reg == `COUNT_FULL)) |=> (timer_count == `COUNT_ZERO) && overflow_flag)
    else $error("Free-running counter did not wrap at full range");

  chk_center_turn: assert property (  // see RULE15
    (tick && center_mode_select && !count_write && !down_reg && at_top && !at_zero)
    |=> down_reg && (timer_count == $past(count_reg) - `COUNT_ONE))
    else $error("Center counter did not turn down at modulo");

  chk_reset_gpio: assert property (  // see RULE21
    disable iff (1'b0) !rst_b |=> (channel_owns_pin == '0) && (channel_pin_oe == '0))
    else $error("Pin not returned to port control after reset");

  chk_idle_gpio: assert property (  // see RULE20
    (edge_level_select[1:0] == `ELS_NONE) |=> !channel_owns_pin[0] && !channel_pin_oe[0])
    else $error("Disabled channel still owns its pin");

  chk_capture_value: assert property (  // see RULE6
    cap_ev[CHANNELS-1] |=> (channel_value[16*CHANNELS-1 -: 16] == $past(count_reg)) &&
    channel_flag[CHANNELS-1])
    else $error("Capture did not store count and set flag");

  chk_flag_sticky: assert property (  // see RULE26
    (channel_flag[0] && !flag_clear[0]) |=> channel_flag[0])
    else $error("Channel flag dropped without a clear");

  chk_request_gate: assert property (  // see RULE26
    channel_request[0] |-> channel_flag[0] && $past(channel_int_enable[0]))
    else $error("Request raised without flag or enable");

  chk_edge_aligned_modulation_start: assert property (  // see RULE25
    (g_ch[0].fn == timer_pkg::fn_edge_pwm && period_start && !match_ev[0])
    |=> (channel_pin_out[0] == !$past(edge_level_select[0])))
    else $error("Edge PWM pin wrong at period start");

  chk_compare_flag: assert property (  // see RULE8
    (g_ch[0].fn == timer_pkg::fn_compare && match_ev[0]) |=> channel_flag[0])
    else $error("Compare match did not set flag");

  chk_owner_release: assert property (  // see RULE20
    !timer_enable |=> (channel_owns_pin == '0) && (channel_pin_oe == '0))
    else $error("Stopped timer still holds a pin");

  chk_center_force: assert property (  // see RULE2
    (center_mode_select && timer_enable && (edge_level_select[1:0] != `ELS_NONE))
    |=> channel_pin_oe[0])
    else $error("Center mode did not take the pin");

  chk_center_active: assert property (  // see RULE16
    (g_ch[0].fn == timer_pkg::fn_center_pwm && match_ev[0] && down_reg && !at_zero)
    |=> (channel_pin_out[0] == !$past(edge_level_select[0])))
    else $error("Center PWM not active on down-count match");

  chk_edge_match: assert property (  // see RULE11
    (g_ch[0].fn == timer_pkg::fn_edge_pwm && match_ev[0])
    |=> (channel_pin_out[0] == $past(edge_level_select[0])))
    else $error("Edge PWM pin wrong at duty match");

  chk_compare_toggle: assert property (  // see RULE9
    (g_ch[0].fn == timer_pkg::fn_compare && match_ev[0] &&
     (edge_level_select[1:0] == `ELS_TOGGLE))
    |=> (channel_pin_out[0] != $past(channel_pin_out[0])))
    else $error("Compare toggle did not invert pin");

  chk_overflow_sticky: assert property (  // see RULE12
    (overflow_flag && !overflow_clear) |=> overflow_flag)
    else $error("Overflow flag dropped without a clear");

  chk_write_quiet: assert property (  // see RULE19
    (count_write && !overflow_flag) |=> !overflow_flag)
    else $error("Counter write raised the overflow flag");

  chk_ext_pace: assert property (  // see RULE23
    (ext_clk_select && !ext_rise && !count_write) |=> $stable(timer_count))
    else $error("Counter moved without an external clock edge");

  cov_capture: cover property (cap_ev[CHANNELS-1] ##1 channel_flag[CHANNELS-1]);
  cov_edge_aligned_modulation_period: cover property (g_ch[0].fn == timer_pkg::fn_edge_pwm && period_start);
  cov_center_turn: cover property (center_mode_select && !down_reg ##1 down_reg);
  cov_set_clear: cover property (set_ev[0] && flag_clear[0]);

endmodule : timer_unit

`default_nettype wire

/* verilog/timer_defs.svh */
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// Counter limits
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define COUNT_FULL 16'hffff

// Edge/level select encodings
`define ELS_NONE 2'h0
`define ELS_TOGGLE 2'h1

// Prescaler shape
`define PRE_ONE 8'h01
`define PRE_STEP 7'h01

`endif

/* verilog/timer_pkg.sv */
package timer_pkg;

  // Function that a channel performs
  typedef enum logic [2:0] {
    fn_off,
    fn_capture,
    fn_compare,
    fn_edge_pwm,
    fn_center_pwm
  } chan_fn_e;

endpackage : timer_pkg

/* verilog/input_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module input_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic async_in,
  output logic rise,
  output logic fall
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Two-stage synchroniser plus a history stage for edge detection
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Edges are seen only on settled samples
  assign rise = sync_reg && !last_reg;
  assign fall = !sync_reg && last_reg;

endmodule : input_sync

`default_nettype wire

/* verif/pin_partner.sv */
`timescale 1ns/100ps
`default_nettype none

module pin_partner #(
  parameter int N = 2
) (
  input wire logic [N-1:0] timer_out,
  input wire logic [N-1:0] timer_oe,
  input wire logic [N-1:0] ext_oe,
  input wire logic [N-1:0] ext_data,
  output logic [N-1:0] pin_level
);
  // Timer drive overrides the pin; else the outside source, else the pull-up
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_level[i] = timer_oe[i] ? timer_out[i] : ext_oe[i] ? ext_data[i] : 1'b1;
    end
  end
endmodule : pin_partner

`default_nettype wire

/* verif/tb_timer_capture_compare_pwm.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_timer_capture_compare_pwm;
  localparam int CH = 2;
  logic clk = 0, rst_b = 0, timer_enable = 0, center_mode_select = 0;
  logic background_debug_mode = 0, count_write = 0, overflow_clear = 0;
  logic overflow_int_enable = 0;
  logic [15:0] modulo_value = 16'h0000;
  logic [3:0] mode_select = 4'h0, edge_level_select = 4'h0;
  logic [1:0] channel_value_wr = 2'h0, flag_clear = 2'h0, channel_int_enable = 2'h0;
  logic [31:0] channel_value_in = 32'h0;
  logic [1:0] ext_oe = 2'h3, ext_data = 2'h0, pin_level;
  logic [15:0] timer_count;
  logic overflow_flag, overflow_request;
  logic [31:0] channel_value;
  logic [1:0] channel_flag, channel_request, channel_owns_pin, channel_pin_out, channel_pin_oe;
  int failures = 0, comparisons = 0, cnt, old, top, cv[2], lastv, mod, pre, mask;
  logic live = 0, up, ovf, ovr, tick, match, step, ext_clk_select = 0;
  logic [2:0] prescale = 3'h0, xs;
  logic [1:0] xdiv = 2'h0;
  logic [1:0] fl, rq, own, oe, pin, m, e, capmask = 2'h0;
  logic [31:0] seed = 32'h591fbb36, r;

  always #25 clk = ~clk;

  // Outside count clock at a quarter of the bus rate
  always @(posedge clk) xdiv <= xdiv + 2'h1;

  timer_unit #(.CHANNELS(CH)) uut (.clk(clk), .rst_b(rst_b), .timer_enable(timer_enable),
    .ext_clk_select(ext_clk_select), .prescale(prescale),
    .center_mode_select(center_mode_select),
    .background_debug_mode(background_debug_mode), .modulo_value(modulo_value),
    .count_write(count_write), .external_count_clock(xdiv[1]), .overflow_clear(overflow_clear),
    .overflow_int_enable(overflow_int_enable), .mode_select(mode_select),
    .edge_level_select(edge_level_select), .channel_value_wr(channel_value_wr),
    .channel_value_in(channel_value_in), .flag_clear(flag_clear),
    .channel_int_enable(channel_int_enable), .channel_pin_in(pin_level),
    .timer_count(timer_count), .overflow_flag(overflow_flag),
    .overflow_request(overflow_request), .channel_value(channel_value),
    .channel_flag(channel_flag), .channel_request(channel_request),
    .channel_owns_pin(channel_owns_pin), .channel_pin_out(channel_pin_out),
    .channel_pin_oe(channel_pin_oe));

  pin_partner #(.N(CH)) pins (.timer_out(channel_pin_out), .timer_oe(channel_pin_oe),
    .ext_oe(ext_oe), .ext_data(ext_data), .pin_level(pin_level));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic finish_test();
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  // Reference model of counter, flags and pins, updated from sampled inputs
  always @(posedge clk) begin
    live = 1;
    if (!rst_b) begin
      cnt = 0; up = 1; ovf = 0; ovr = 0; fl = 0; rq = 0; own = 0; oe = 0; pin = 0; cv = '{0, 0};
      xs = 3'h0;
      pre = 0;
    end else begin
      top = (modulo_value == 16'h0000) ? 65535 : int'(modulo_value);
      mask = (1 << prescale) - 1;
      step = timer_enable && !background_debug_mode;
      if (ext_clk_select) step = step && xs[1] && !xs[2];
      tick = step && (pre & mask) == mask && !count_write;
      pre = count_write ? 0 : step ? (pre + 1) % 128 : pre;
      xs = {xs[1:0], xdiv[1]};
      old = cnt;
      if (count_write) begin
        cnt = 0;
        up = 1;
      end else if (tick && center_mode_select) begin
        cnt = up ? cnt + 1 : cnt - 1;
        up = (cnt >= top) ? 1'b0 : (cnt == 0) ? 1'b1 : up;
      end else if (tick) cnt = (cnt >= top) ? 0 : cnt + 1;
      ovf = (tick && old == top) || (ovf && !overflow_clear);
      ovr = ovf && overflow_int_enable;
      for (int i = 0; i < CH; i++) begin
        m = mode_select[2*i +: 2];
        e = edge_level_select[2*i +: 2];
        own[i] = timer_enable && e != 2'h0;
        oe[i] = own[i] && (center_mode_select || m != 2'h0);
        match = tick && oe[i] && cnt == cv[i];
        if (center_mode_select && match) pin[i] = (cnt < old) ^ e[0];
        else if (!center_mode_select && m[1] && tick && own[i] && cnt == 0) pin[i] = !e[0];
        if (!center_mode_select && m[1] && match) pin[i] = e[0];
        if (!center_mode_select && m == 2'h1 && match) pin[i] = (e == 2'h1) ? !pin[i] : e[0];
        fl[i] = match || (fl[i] && !flag_clear[i]);
        rq[i] = fl[i] && channel_int_enable[i];
        if (channel_value_wr[i]) cv[i] = channel_value_in[16*i +: 16];
      end
    end
  end

  // Compare the design with the model in mid cycle
  always @(negedge clk) if (live) begin
    check("timer_count", cnt, timer_count);
    check("overflow_flag", ovf, overflow_flag);
    check("overflow_request", ovr, overflow_request);
    for (int i = 0; i < CH; i++) begin
      check("channel_owns_pin", own[i], channel_owns_pin[i]);
      check("channel_pin_oe", oe[i], channel_pin_oe[i]);
      if (oe[i]) check("channel_pin_out", pin[i], channel_pin_out[i]);
      if (!capmask[i]) begin
        check("channel_flag", fl[i], channel_flag[i]);
        check("channel_request", rq[i], channel_request[i]);
        check("channel_value", cv[i], channel_value[16*i +: 16]);
      end
    end
  end

  // Edge pulses on channel 1 with the counter frozen around each edge
  task automatic capture(input logic [1:0] ev);
    int c0;
    int c1;
    edge_level_select[3:2] <= ev;
    flag_clear <= 2'h2;
    background_debug_mode <= 1;
    @(posedge clk);
    flag_clear <= 2'h0;
    repeat (2) @(posedge clk);
    c0 = cnt;
    ext_data[1] <= 1;
    repeat (6) @(posedge clk);
    background_debug_mode <= 0;
    repeat (3) @(posedge clk);
    background_debug_mode <= 1;
    repeat (2) @(posedge clk);
    c1 = cnt;
    ext_data[1] <= 0;
    repeat (6) @(posedge clk);
    if (ev != 2'h0) lastv = (ev == 2'h1) ? c0 : c1;
    @(negedge clk);
    check("capture_flag", ev != 2'h0, channel_flag[1]);
    check("capture_value", lastv, channel_value[31:16]);
  endtask : capture

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1;
    // Random compare and edge PWM modes, then center mode, each started by a counter write
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      mod = 3 + r[2:0];
      center_mode_select <= (k >= 8);
      modulo_value <= 16'(mod);
      count_write <= 1;
      timer_enable <= r[3] | r[4];
      mode_select <= {(r[6:5] == 2'h0) ? 2'h1 : r[6:5], (r[8:7] == 2'h0) ? 2'h1 : r[8:7]};
      edge_level_select <= r[12:9];
      channel_value_in <= {16'(1 + r[19:16] % mod), 16'(1 + r[23:20] % mod)};
      channel_value_wr <= 2'h3;
      channel_int_enable <= r[25:24];
      overflow_int_enable <= r[26];
      ext_clk_select <= r[29];
      prescale <= {1'b0, r[28:27]};
      @(posedge clk);
      channel_value_wr <= 2'h0;
      repeat (50) begin
        r = rnd();
        flag_clear <= r[1:0] & {2{r[2]}};
        overflow_clear <= r[3] & r[4];
        background_debug_mode <= (r[7:5] == 3'h0);
        count_write <= (r[15:8] == 8'h0);
        @(posedge clk);
      end
    end
    // Free-running full range with modulo zero
    center_mode_select <= 0;
    ext_clk_select <= 0;
    prescale <= 3'h0;
    modulo_value <= 16'h0000;
    timer_enable <= 1;
    count_write <= 1;
    background_debug_mode <= 0;
    flag_clear <= 2'h0;
    overflow_clear <= 0;
    edge_level_select[3:2] <= 2'h0;
    @(posedge clk);
    count_write <= 0;
    repeat (65540) @(posedge clk);
    mode_select[3:2] <= 2'h0;
    capmask[1] = 1;
    repeat (4) @(posedge clk);
    capture(2'h1);
    capture(2'h2);
    capture(2'h3);
    capture(2'h0);
    finish_test();
  end
endmodule : tb_timer_capture_compare_pwm

`default_nettype wire
